// >>> phy_test_pkg.sv
/*
 * Constants for the per-port transceiver test and override register bank:
 * register offsets, bit positions and reset value.
 * Assumes an 8-bit switch register space with byte-wide registers.
 */
package phy_test_pkg;

    localparam int          NUM_PORTS   = 5;
    localparam int          ADDR_W      = 8;
    localparam int          DATA_W      = 8;

    // one test-control register per port, first port through fifth
    localparam logic [7:0]  PORT1_PHY_TEST_CONTROL = 8'h1f;
    localparam logic [7:0]  PORT2_PHY_TEST_CONTROL = 8'h2f;
    localparam logic [7:0]  PORT3_PHY_TEST_CONTROL = 8'h3f;
    localparam logic [7:0]  PORT4_PHY_TEST_CONTROL = 8'h4f;
    localparam logic [7:0]  PORT5_PHY_TEST_CONTROL = 8'h5f;
    localparam logic [7:0]  TEST_CTRL_ADDR [NUM_PORTS] = '{
        PORT1_PHY_TEST_CONTROL, PORT2_PHY_TEST_CONTROL, PORT3_PHY_TEST_CONTROL,
        PORT4_PHY_TEST_CONTROL, PORT5_PHY_TEST_CONTROL};

    // field positions
    localparam int          BIT_NEAR_SIDE_ECHO   = 7;
    localparam int          BIT_REMOTE_ECHO      = 6;
    localparam int          BIT_XCVR_ISOLATION   = 5;
    localparam int          BIT_SOFT_RESET       = 4;
    localparam int          BIT_FORCE_LINK       = 3;
    localparam int          BIT_RSVD_HI          = 2;
    localparam int          BIT_RSVD_LO          = 1;
    localparam int          BIT_FAR_FAULT        = 0;

    localparam logic [7:0]  TEST_CTRL_RESET = 8'h00;
    localparam logic [7:0]  UNMAPPED_READ   = 8'h00;
    localparam logic [1:0]  RSVD_VALUE      = 2'h0;

endpackage

// >>> port_test_cell.sv
/*
 * One port's test-control register: writable control bits, self-clearing
 * soft reset and the far-end-fault status flag.
 * Assumes a one-cycle write strobe from the decoder and a one-cycle
 * reset-done pulse from the port's transceiver.
 */
`timescale 1ns/1ps

module port_test_cell
    import phy_test_pkg::*;
#(
    parameter bit SELF_CLEAR = 1'b1                // soft reset clears itself when done
)(
    input  wire logic              i_clk,          // core clock
    input  wire logic              i_rst,          // synchronous reset, high
    input  wire logic              i_wr,           // write strobe for this register
    input  wire logic [DATA_W-1:0] i_wdata,        // write data
    input  wire logic              i_reset_done,   // transceiver finished soft reset
    input  wire logic              i_far_fault,    // far end fault seen on the line
    input  wire logic              i_fault_off,    // fault detection disabled
    output logic                   o_near_echo,    // mac tx looped to rx
    output logic                   o_remote_echo,  // line rx looped to tx
    output logic                   o_isolate,      // transceiver isolation
    output logic                   o_soft_reset,   // transceiver soft reset
    output logic                   o_force_link,   // link forced up
    output logic                   o_fault,        // far end fault flag
    output logic                   o_fault_tx_en,  // fault detect and pattern enable
    output logic [DATA_W-1:0]      o_value         // register read value
);

    logic next_soft_reset;
    logic next_fault;

    // a write of one wins over the completion clear in the same cycle
    assign next_soft_reset = i_wr ? i_wdata[BIT_SOFT_RESET]
                           : ((SELF_CLEAR && i_reset_done) ? 1'b0 : o_soft_reset);
    assign next_fault      = i_far_fault & ~i_fault_off;

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_near_echo   <= 1'b0;
            o_remote_echo <= 1'b0;
            o_isolate     <= 1'b0;
            o_soft_reset  <= 1'b0;
            o_force_link  <= 1'b0;
        end
        else if (i_wr)
        begin
            o_near_echo   <= i_wdata[BIT_NEAR_SIDE_ECHO];
            o_remote_echo <= i_wdata[BIT_REMOTE_ECHO];
            o_isolate     <= i_wdata[BIT_XCVR_ISOLATION];
            o_force_link  <= i_wdata[BIT_FORCE_LINK];
            o_soft_reset  <= next_soft_reset;
        end
        else
        begin
            o_soft_reset  <= next_soft_reset;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_fault       <= 1'b0;
            o_fault_tx_en <= 1'b1;
        end
        else
        begin
            o_fault       <= next_fault;
            o_fault_tx_en <= ~i_fault_off;
        end
    end

    // status bit and reserved bits come from hardware only, never from a write
    assign o_value = {o_near_echo, o_remote_echo, o_isolate, o_soft_reset,
                      o_force_link, RSVD_VALUE, o_fault};

    sequence reset_write_s;
        i_wr && i_wdata[BIT_SOFT_RESET];
    endsequence

    sequence done_no_write_s;
        i_reset_done && !i_wr;
    endsequence

    echo_follows_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_wr |=> o_near_echo == $past(i_wdata[BIT_NEAR_SIDE_ECHO]))
        else $error("near side echo did not follow write");

    remote_holds_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_wr ##1 !i_wr) |-> o_remote_echo == $past(i_wdata[BIT_REMOTE_ECHO]))
        else $error("remote echo lost its written value");

    isolate_follows_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_wr |=> $stable(o_isolate))
        else $error("isolation changed without a write");

    soft_reset_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_soft_reset ##0 done_no_write_s |=> o_soft_reset == !SELF_CLEAR)
        else $error("soft reset did not clear on completion");

    soft_reset_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
        reset_write_s |=> o_soft_reset)
        else $error("soft reset write lost");

    force_link_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_wr |=> o_force_link == $past(i_wdata[BIT_FORCE_LINK]))
        else $error("force link did not follow write");

    fault_flag_a: assert property (@(posedge i_clk) disable iff (i_rst)
        ##1 o_fault == $past(i_far_fault && !i_fault_off))
        else $error("fault flag does not track detection");

    fault_masked_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_fault_off [*2] |-> !o_fault && !o_fault_tx_en)
        else $error("fault active while detection disabled");

    reserved_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_wr |=> o_value[BIT_RSVD_HI:BIT_RSVD_LO] == RSVD_VALUE)
        else $error("reserved bits took write data");

    reset_clear_a: assert property (@(posedge i_clk)
        $fell(i_rst) |-> !o_near_echo && !o_remote_echo && !o_isolate
                         && !o_soft_reset && !o_force_link)
        else $error("control bits not cleared by reset");

endmodule // port_test_cell

// >>> port_phy_test_control.sv
/*
 * Register bank holding one transceiver test-control register per switch
 * port, reached through the switch's byte-wide register interface.
 * Assumes the serial management front end supplies address, one-cycle
 * write and read strobes, and takes read data one cycle after the strobe.
 */
`timescale 1ns/1ps

module port_phy_test_control
    import phy_test_pkg::*;
#(
    parameter bit SELF_CLEAR = 1'b1                     // later revisions self-clear
)(
    input  wire logic                 I_CLK_SYS,        // core clock, 100 MHz
    input  wire logic                 I_RST,            // synchronous reset, high
    input  wire logic [ADDR_W-1:0]    I_REG_ADDR,       // register address
    input  wire logic                 I_REG_WR,         // write strobe
    input  wire logic [DATA_W-1:0]    I_REG_WDATA,      // write data
    input  wire logic                 I_REG_RD,         // read strobe
    input  wire logic [NUM_PORTS-1:0] I_RESET_DONE,     // soft reset finished, per port
    input  wire logic [NUM_PORTS-1:0] I_FAR_FAULT,      // far end fault detected, per port
    input  wire logic [NUM_PORTS-1:0] I_FAULT_OFF,      // fault detection disabled, per port
    output logic [NUM_PORTS-1:0]      O_NEAR_SIDE_ECHO, // mac tx to rx loopback
    output logic [NUM_PORTS-1:0]      O_REMOTE_ECHO,    // line rx to tx loopback
    output logic [NUM_PORTS-1:0]      O_ISOLATION,      // transceiver isolation
    output logic [NUM_PORTS-1:0]      O_SOFT_RESET,     // transceiver soft reset
    output logic [NUM_PORTS-1:0]      O_FORCE_LINK,     // link forced up
    output logic [NUM_PORTS-1:0]      O_FAULT_TX_EN,    // fault detect and pattern enable
    output logic [DATA_W-1:0]         O_REG_RDATA,      // read data
    output logic                      O_REG_RVALID      // read data valid pulse
);

    logic [NUM_PORTS-1:0] port_sel;
    logic [NUM_PORTS-1:0] port_wr;
    logic [NUM_PORTS-1:0] fault_flag;
    logic [DATA_W-1:0]    port_value [NUM_PORTS];
    logic [DATA_W-1:0]    next_rdata;

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++)
        begin : g_port
            assign port_sel[p] = (I_REG_ADDR == TEST_CTRL_ADDR[p]);
            assign port_wr[p]  = I_REG_WR & port_sel[p];

            port_test_cell #(
                .SELF_CLEAR (SELF_CLEAR)
            ) u_cell (
                .i_clk         (I_CLK_SYS),
                .i_rst         (I_RST),
                .i_wr          (port_wr[p]),
                .i_wdata       (I_REG_WDATA),
                .i_reset_done  (I_RESET_DONE[p]),
                .i_far_fault   (I_FAR_FAULT[p]),
                .i_fault_off   (I_FAULT_OFF[p]),
                .o_near_echo   (O_NEAR_SIDE_ECHO[p]),
                .o_remote_echo (O_REMOTE_ECHO[p]),
                .o_isolate     (O_ISOLATION[p]),
                .o_soft_reset  (O_SOFT_RESET[p]),
                .o_force_link  (O_FORCE_LINK[p]),
                .o_fault       (fault_flag[p]),
                .o_fault_tx_en (O_FAULT_TX_EN[p]),
                .o_value       (port_value[p])
            );
        end
    endgenerate

    // unmapped addresses read as zero
    always_comb
    begin
        next_rdata = UNMAPPED_READ;
        for (int i = 0; i < NUM_PORTS; i++)
        begin
            if (port_sel[i])
            begin
                next_rdata = port_value[i];
            end
        end
    end

    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_RST)
        begin
            O_REG_RDATA  <= TEST_CTRL_RESET;
            O_REG_RVALID <= 1'b0;
        end
        else
        begin
            O_REG_RDATA  <= I_REG_RD ? next_rdata : O_REG_RDATA;
            O_REG_RVALID <= I_REG_RD;
        end
    end

    unmapped_read_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        (I_REG_RD && port_sel == '0) |=> O_REG_RDATA == UNMAPPED_READ && O_REG_RVALID)
        else $error("unmapped read did not return zero");

    fault_readback_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        (I_REG_RD && port_sel[0]) |=> O_REG_RDATA[BIT_FAR_FAULT] == $past(fault_flag[0]))
        else $error("fault flag not seen on read");

    write_isolated_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        (I_REG_WR && !port_sel[1]) |=> $stable(O_FORCE_LINK[1]))
        else $error("write to another address changed port two");

endmodule // port_phy_test_control

// >>> xcvr_model.sv
/* transceiver stand-in: answers each soft reset with a done pulse after
   a delay. assumes the bank's soft reset outputs and a bench enable. */
`timescale 1ns/1ps

module xcvr_model (
    input  wire logic       i_clk,               // core clock
    input  wire logic       i_en,                // answer soft resets
    input  wire logic [3:0] i_delay,             // cycles before done
    input  wire logic [4:0] i_soft_reset,        // reset request per port
    output logic      [4:0] o_reset_done = 5'h00 // done pulse per port
);
    logic [3:0] cnt = 4'h0;
    always_ff @(posedge i_clk)
    begin
        o_reset_done <= 5'h00;
        cnt          <= (!i_en || i_soft_reset == 5'h00 || cnt == i_delay) ? 4'h0 : cnt + 4'h1;
        if (i_en && i_soft_reset != 5'h00 && cnt == i_delay)
            o_reset_done <= i_soft_reset;
    end
endmodule // xcvr_model

// >>> port_phy_test_control_test.sv
/* self-checking bench for the test-control bank: reset values, random
   writes and reads, unmapped access, soft reset, fault flag. assumes the
   transceiver stand-in drives the done pulses. */
`timescale 1ns/1ps

module port_phy_test_control_test;
    import phy_test_pkg::*;
    logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, en = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d, rdv;
    logic [4:0] far = 5'h00, off = 5'h00, done, echo, remote, iso, sr, frc, ften, f, m;
    logic [3:0] dly = 4'h0;
    logic       rvalid, rvs;
    logic [31:0] snap;
    int         n_fail = 0, cmp_count = 0, cycles = 0, p, k;

    port_phy_test_control i_port_phy_test_control (.I_CLK_SYS(clk), .I_RST(rst),
        .I_REG_ADDR(addr), .I_REG_WR(wr), .I_REG_WDATA(wdata), .I_REG_RD(rd),
        .I_RESET_DONE(done), .I_FAR_FAULT(far), .I_FAULT_OFF(off),
        .O_NEAR_SIDE_ECHO(echo), .O_REMOTE_ECHO(remote), .O_ISOLATION(iso),
        .O_SOFT_RESET(sr), .O_FORCE_LINK(frc), .O_FAULT_TX_EN(ften),
        .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid));
    xcvr_model i_xcvr_model (.i_clk(clk), .i_en(en), .i_delay(dly), .i_soft_reset(sr),
        .o_reset_done(done));

    always #5 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            n_fail++;
            finish_test();
        end
    end

    function automatic logic [7:0] exp_rd(input logic [7:0] v, input logic flt);
        return {v[7:3], 2'b00, flt};
    endfunction
    function automatic logic [7:0] port_bits(input int q);
        return {echo[q], remote[q], iso[q], sr[q], frc[q], 3'b000};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a; wdata <= v; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic reg_rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        rdv = rdata;
        rvs = rvalid;
    endtask
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        void'($urandom(32'hfbfa));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk({echo, remote, iso, sr, frc}, 32'h0);
        chk(ften, 5'h1f);
        for (p = 0; p < 5; p++)
        begin
            reg_rd(TEST_CTRL_ADDR[p]);
            chk({rvs, rdv}, 9'h100);
        end
        $display("test reset values done");
        repeat (40)
        begin
            p = $urandom % 5;
            d = 8'($urandom);
            f = 5'($urandom);
            far <= f;
            reg_wr(TEST_CTRL_ADDR[p], d);
            chk(port_bits(p), {d[7:3], 3'b000});
            reg_rd(TEST_CTRL_ADDR[p]);
            chk({rvs, rdv}, {1'b1, exp_rd(d, f[p])});
        end
        $display("test random access done");
        snap = {echo, remote, iso, sr, frc};
        reg_wr(8'h1e, 8'hff);
        chk({echo, remote, iso, sr, frc}, snap);
        reg_rd(8'h60);
        chk({rvs, rdv}, 9'h100);
        $display("test unmapped done");
        far <= 5'h00; en <= 1'b1;
        for (p = 0; p < 5; p++)
        begin
            dly <= 4'($urandom % 8);
            reg_wr(TEST_CTRL_ADDR[p], 8'h10);
            chk(sr[p], 1'b1);
            for (k = 0; k < 20 && sr[p] === 1'b1; k++)
                @(posedge clk);
            #1;
            chk(sr[p], 1'b0);
            reg_rd(TEST_CTRL_ADDR[p]);
            chk(rdv, 8'h00);
        end
        $display("test soft reset done");
        m = 5'($urandom) | 5'h01;
        far <= 5'h1f; off <= m;
        repeat (2) @(posedge clk);
        #1;
        chk(ften, 5'(~m));
        for (p = 0; p < 5; p++)
        begin
            reg_rd(TEST_CTRL_ADDR[p]);
            chk(rdv, exp_rd(8'h00, ~m[p]));
        end
        $display("test fault disable done");
        finish_test();
    end
endmodule // port_phy_test_control_test
